// ---- src/eid_ext_irq_detect.sv ----
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module eid_ext_irq_detect #(
   parameter int NumCh = eid_pkg::NumCh
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [eid_pkg::AddrW-1:0] regAddr,
   input wire logic [eid_pkg::DataW-1:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [eid_pkg::DataW-1:0] regRdata,
   input wire logic [NumCh-1:0] extIrqPin,
   input wire logic [NumCh-1:0] portInvert,
   input wire logic tcycEn,
   input wire logic [1:0] timer2CountSel,
   input wire logic [1:0] timer2LowSel,
   input wire logic [1:0] timer2HighSel,
   input wire logic timer3CountSel,
   input wire logic standbyRc,
   input wire logic standbyKeepOsc,
   input wire logic irqAccept,
   output logic [NumCh-1:0] irqRequest,
   output logic standbyWake,
   output logic wakeToRcHalt,
   output logic wakeToKeepHalt,
   output logic haltExit,
   output logic timer2CountPulse,
   output logic timer2LowCapture,
   output logic timer2HighCapture,
   output logic timer3CountPulse
);
   import eid_pkg::*;

   logic [NumCh-1:0] sync1Reg;
   logic [NumCh-1:0] sync2Reg;
   logic [NumCh-1:0] prevReg;
   logic [NumCh-1:0] entryLevelReg;
   logic standbyReg;
   logic [1:0] modeReg [NumCh];
   logic [NumCh-1:0] flagReg;
   logic [NumCh-1:0] enableReg;
   logic [NumCh-1:0] hit;
   logic [NumCh-1:0] levelMode;
   logic [NumCh-1:0] levelActive;
   logic [NumCh-1:0] hitRepeat;
   logic tcycPhaseReg;
   logic repeatTick;
   logic inStandby;
   eid_wake_e wakeReg;
   eid_wake_e wakeNext;
   logic [1:0] fillReg;
   logic pipeValid;
   logic [NumCh-1:0] fallEv;
   logic [NumCh-1:0] riseEv;
   logic [NumCh-1:0] wrSel;
   logic [NumCh-1:0] wrFlag;
   logic [NumCh-1:0] wrEnable;
   logic [ModeW-1:0] wrMode [NumCh];
   logic selT2Count;
   logic selT2Low;
   logic selT2High;
   logic selT3Count;

   // Register index of a bus address, or -1 when unmapped.
   function automatic int regIndex(input logic [AddrW-1:0] addr);
      case (addr)
         AddrCtrl01: regIndex = 0;
         AddrCtrl23: regIndex = 1;
         AddrCtrl45: regIndex = 2;
         AddrCtrl67: regIndex = 3;
         default: regIndex = -1;
      endcase
   endfunction : regIndex

   // True for the odd channel of a pair, which lives in the upper nibble.
   function automatic logic isUpper(input int ch);
      isUpper = (ch % ChPerReg) == 1;
   endfunction : isUpper

   function automatic logic [ModeW-1:0] fieldMode(input logic [DataW-1:0] data, input logic upper);
      fieldMode = upper ? data[HiModeLsb+:ModeW] : data[LoModeLsb+:ModeW];
   endfunction : fieldMode

   function automatic logic fieldFlag(input logic [DataW-1:0] data, input logic upper);
      fieldFlag = upper ? data[HiFlagBit] : data[LoFlagBit];
   endfunction : fieldFlag

   function automatic logic fieldEnable(input logic [DataW-1:0] data, input logic upper);
      fieldEnable = upper ? data[HiEnBit] : data[LoEnBit];
   endfunction : fieldEnable

   // Builds one control byte from the state of a channel pair.
   function automatic logic [DataW-1:0] pairByte(input logic [ModeW-1:0] loMode, input logic loFlag,
         input logic loEn, input logic [ModeW-1:0] hiMode, input logic hiFlag, input logic hiEn);
      pairByte = CtrlReset;
      pairByte[HiModeLsb+:ModeW] = hiMode;
      pairByte[HiFlagBit] = hiFlag;
      pairByte[HiEnBit] = hiEn;
      pairByte[LoModeLsb+:ModeW] = loMode;
      pairByte[LoFlagBit] = loFlag;
      pairByte[LoEnBit] = loEn;
   endfunction : pairByte

   // Picks the strobe of the channel that a timer source select names.
   function automatic logic pickSource(input logic [NumCh-1:0] strobes, input int ch);
      pickSource = strobes[ch];
   endfunction : pickSource

   // One synchronised level per channel, polarity applied before the flops so that
   // inverted pins read as active-low for the detectors below.
   always_ff @(posedge clock) begin
      if (rst) begin
         sync1Reg <= '0;
         sync2Reg <= '0;
      end else begin
         sync1Reg <= extIrqPin ^ portInvert;
         sync2Reg <= sync1Reg;
      end
   end

   // Only the second stage feeds the previous-level register, keeping the first stage private.
   always_ff @(posedge clock) begin
      if (rst) begin
         prevReg <= '0;
      end else begin
         prevReg <= sync2Reg;
      end
   end

   // Detection waits until both stages and the previous-level register hold real pin samples; without this the zero reset
   // value would look like an edge or an active low level on an idle high pin.
   always_ff @(posedge clock) begin
      if (rst) begin
         fillReg <= '0;
      end else if (fillReg != SyncFill) begin
         fillReg <= fillReg + 2'h1;
      end
   end
   assign pipeValid = (fillReg == SyncFill);
   assign fallEv = pipeValid ? (prevReg & ~sync2Reg) : '0;
   assign riseEv = pipeValid ? (~prevReg & sync2Reg) : '0;

   assign inStandby = standbyRc | standbyKeepOsc;

   // Standby entry is the first cycle in which either standby level is high.
   always_ff @(posedge clock) begin
      if (rst) begin
         standbyReg <= 1'b0;
      end else begin
         standbyReg <= inStandby;
      end
   end

   // The level at standby entry is frozen so that an edge returning towards it is ignored.
   always_ff @(posedge clock) begin
      if (rst) begin
         entryLevelReg <= '0;
      end else if (inStandby && !standbyReg) begin
         entryLevelReg <= sync2Reg;
      end
   end

   // The two-cycle phase advances only when tcycEn is high; level repeats land on its enabled half.
   always_ff @(posedge clock) begin
      if (rst) begin
         tcycPhaseReg <= 1'b0;
      end else if (tcycEn) begin
         tcycPhaseReg <= ~tcycPhaseReg;
      end
   end
   assign repeatTick = tcycEn & tcycPhaseReg;

   always_comb begin
      for (int i = 0; i < NumCh; i++) begin
         levelMode[i] = (modeReg[i] == ModeLevel);
         levelActive[i] = pipeValid & levelMode[i] & ~sync2Reg[i];
      end
   end

   always_comb begin
      for (int i = 0; i < NumCh; i++) begin
         logic blockRise;
         logic blockFall;
         blockRise = inStandby & entryLevelReg[i];
         blockFall = inStandby & ~entryLevelReg[i];
         case (modeReg[i])
            ModeOff: hit[i] = 1'b0;
            ModeLevel: hit[i] = levelActive[i];
            ModeFall: hit[i] = fallEv[i] & ~blockFall;
            ModeBoth: hit[i] = (fallEv[i] & ~blockFall) | (riseEv[i] & ~blockRise);
            default: hit[i] = 1'b0;
         endcase
      end
   end

   // Level channels feed the timers only on the repeat tick; edge channels pass every detection.
   always_comb begin
      for (int i = 0; i < NumCh; i++) begin
         hitRepeat[i] = levelMode[i] ? (levelActive[i] & repeatTick) : hit[i];
      end
   end

   // Write decode per channel; a pair shares one byte, so both channels see the same strobe.
   always_comb begin
      for (int i = 0; i < NumCh; i++) begin
         wrSel[i] = regWrite && (regIndex(regAddr) == i / ChPerReg);
         wrMode[i] = fieldMode(regWdata, isUpper(i));
         wrFlag[i] = fieldFlag(regWdata, isUpper(i));
         wrEnable[i] = fieldEnable(regWdata, isUpper(i));
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         for (int i = 0; i < NumCh; i++) begin
            modeReg[i] <= CtrlReset[LoModeLsb+:ModeW];
         end
      end else begin
         for (int i = 0; i < NumCh; i++) begin
            if (wrSel[i]) begin
               modeReg[i] <= wrMode[i];
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         enableReg <= '0;
      end else begin
         for (int i = 0; i < NumCh; i++) begin
            if (wrSel[i]) begin
               enableReg[i] <= wrEnable[i];
            end
         end
      end
   end

   // A detection in the clearing cycle wins, so an event is never lost to a software clear.
   // The hardware itself has no path that clears a flag.
   always_ff @(posedge clock) begin
      if (rst) begin
         flagReg <= '0;
      end else begin
         for (int i = 0; i < NumCh; i++) begin
            if (hit[i]) begin
               flagReg[i] <= 1'b1;
            end else if (wrSel[i]) begin
               flagReg[i] <= wrFlag[i];
            end
         end
      end
   end

   // Unmapped addresses read as zero so software can probe the space safely.
   always_ff @(posedge clock) begin
      if (rst) begin
         regRdata <= '0;
      end else if (regRead) begin
         regRdata <= '0;
         for (int p = 0; p < NumCh / ChPerReg; p++) begin
            if (regIndex(regAddr) == p) begin
               regRdata <= pairByte(modeReg[ChPerReg*p], flagReg[ChPerReg*p], enableReg[ChPerReg*p],
                  modeReg[ChPerReg*p+1], flagReg[ChPerReg*p+1], enableReg[ChPerReg*p+1]);
            end
         end
      end
   end

   // Request and wake are combinational from flag and enable, so the core sees a set flag
   // in the same cycle as the register holds it.
   assign irqRequest = flagReg & enableReg;
   assign standbyWake = |irqRequest;

   function automatic logic isHalted(input eid_wake_e state);
      isHalted = (state == EID_HALT_RC) || (state == EID_HALT_KEEP);
   endfunction : isHalted

   // Halt state after a wake; the kind of halt tells the clock controller which
   // oscillator to run until the request is taken.
   always_comb begin
      wakeNext = wakeReg;
      case (wakeReg)
         EID_RUN: begin
            if (standbyRc && standbyWake) begin
               wakeNext = EID_HALT_RC;
            end else if (standbyKeepOsc && standbyWake) begin
               wakeNext = EID_HALT_KEEP;
            end
         end
         EID_HALT_RC, EID_HALT_KEEP: begin
            if (irqAccept) begin
               wakeNext = EID_RUN;
            end
         end
         default: wakeNext = EID_RUN;
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wakeReg <= EID_RUN;
      end else begin
         wakeReg <= wakeNext;
      end
   end

   assign wakeToRcHalt = (wakeReg == EID_HALT_RC);
   assign wakeToKeepHalt = (wakeReg == EID_HALT_KEEP);
   assign haltExit = isHalted(wakeReg) && irqAccept;

   // Each timer source is chosen before its register, so an unselected channel never reaches
   // a timer. Only bit 0 of the timer 2 count select matters, as there are two sources.
   always_comb begin
      selT2Count = pickSource(hitRepeat, T2CountSrc[timer2CountSel[0]]);
      selT2Low = pickSource(hitRepeat, T2LowSrc[timer2LowSel]);
      selT2High = pickSource(hitRepeat, T2HighSrc[timer2HighSel]);
      selT3Count = pickSource(hitRepeat, T3CountSrc[timer3CountSel]);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         timer2CountPulse <= 1'b0;
      end else begin
         timer2CountPulse <= selT2Count;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         timer2LowCapture <= 1'b0;
      end else begin
         timer2LowCapture <= selT2Low;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         timer2HighCapture <= 1'b0;
      end else begin
         timer2HighCapture <= selT2High;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         timer3CountPulse <= 1'b0;
      end else begin
         timer3CountPulse <= selT3Count;
      end
   end
endmodule : eid_ext_irq_detect

// ---- src/eid_pkg.sv ----
package eid_pkg;
   localparam int NumCh = 8;
   localparam int AddrW = 16;
   localparam int DataW = 8;
   localparam logic [15:0] AddrCtrl01 = 16'h7fd8;
   localparam logic [15:0] AddrCtrl23 = 16'h7fd9;
   localparam logic [15:0] AddrCtrl45 = 16'h7fda;
   localparam logic [15:0] AddrCtrl67 = 16'h7fdb;
   localparam logic [7:0] CtrlReset = 8'h00;
   localparam int LoModeLsb = 2;
   localparam int LoFlagBit = 1;
   localparam int LoEnBit = 0;
   localparam int HiModeLsb = 6;
   localparam int HiFlagBit = 5;
   localparam int HiEnBit = 4;
   localparam logic [1:0] ModeOff = 2'h0;
   localparam logic [1:0] ModeLevel = 2'h1;
   localparam logic [1:0] ModeFall = 2'h2;
   localparam logic [1:0] ModeBoth = 2'h3;
   localparam int RepeatTcyc = 2;
   localparam int ModeW = 2;
   localparam int ChPerReg = 2;
   localparam logic [1:0] SyncFill = 2'h3;
   localparam int T2CountSrc[2] = '{2, 3};
   localparam int T2LowSrc[4] = '{0, 2, 4, 5};
   localparam int T2HighSrc[4] = '{1, 3, 4, 5};
   localparam int T3CountSrc[2] = '{4, 5};
   typedef enum logic [1:0] {
      EID_RUN,
      EID_HALT_RC,
      EID_HALT_KEEP
   } eid_wake_e;
endpackage : eid_pkg

// ---- testbench/eid_core_model.sv ----
`timescale 1ns/1ps
module eid_core_model (
   input wire logic clock,
   input wire logic rst,
   input wire logic halted,
   input wire logic acceptOn,
   input wire logic [3:0] pulses,
   output logic tcycEn = 1'b0,
   output logic irqAccept = 1'b0,
   output logic [3:0][7:0] count
);
   // An instruction cycle is two clocks, so level repeats come every four clocks.
   always_ff @(posedge clock) begin
      tcycEn <= rst ? 1'b0 : ~tcycEn;
   end
   // One acceptance per halt; holding it high would hide a missing exit.
   always_ff @(posedge clock) begin
      irqAccept <= !rst && acceptOn && halted && !irqAccept;
   end
   always_ff @(posedge clock) begin
      for (int i = 0; i < 4; i++) begin
         count[i] <= rst ? 8'h00 : count[i] + 8'(pulses[i]);
      end
   end
endmodule : eid_core_model

// ---- testbench/eid_ext_irq_checker.sv ----
`timescale 1ns/1ps
module eid_ext_irq_checker #(
   parameter int NumCh = 8
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic regWrite,
   input wire logic standbyRc,
   input wire logic standbyKeepOsc,
   input wire logic irqAccept,
   input wire logic [NumCh-1:0] irqRequest,
   input wire logic standbyWake,
   input wire logic wakeToRcHalt,
   input wire logic wakeToKeepHalt,
   input wire logic haltExit,
   input wire logic timer2CountPulse
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_halted;
      wakeToRcHalt || wakeToKeepHalt;
   endsequence
   sequence s_wakeReq;
      standbyWake && !irqAccept;
   endsequence
   a_wake_any: assert property (standbyWake == (|irqRequest)) else $error("wake differs from requests");
   a_rc_wake: assert property (s_wakeReq ##0 standbyRc && !wakeToKeepHalt |=> wakeToRcHalt)
      else $error("no RC halt after wake");
   a_keep_wake: assert property (s_wakeReq ##0 standbyKeepOsc && !standbyRc && !wakeToRcHalt |=> wakeToKeepHalt)
      else $error("no kept halt after wake");
   a_exit_pulse: assert property (haltExit == (irqAccept && (wakeToRcHalt || wakeToKeepHalt)))
      else $error("halt exit mismatch");
   a_exit_run: assert property (s_halted ##0 irqAccept && !standbyRc && !standbyKeepOsc |=>
      !wakeToRcHalt && !wakeToKeepHalt) else $error("halt kept after accept");
   a_flag_sticky: assert property (|($past(irqRequest) & ~irqRequest) |-> $past(regWrite) || $past(rst))
      else $error("request dropped without write");
   a_t2_single: assert property (timer2CountPulse |=> !timer2CountPulse) else $error("count pulse too long");
   a_halt_one: assert property (!(wakeToRcHalt && wakeToKeepHalt)) else $error("both halt states");
endmodule : eid_ext_irq_checker

// ---- testbench/eid_ext_irq_detect_bench.sv ----
`timescale 1ns/1ps
module eid_ext_irq_detect_bench;
   import eid_pkg::*;
   logic clock = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0, standbyRc = 1'b0, standbyKeepOsc = 1'b0;
   logic [15:0] regAddr = 16'h0000;
   logic [7:0] regWdata = 8'h00, regRdata, extIrqPin = 8'hff, portInvert = 8'h00, irqRequest;
   logic [1:0] timer2CountSel = 2'h1, timer2LowSel = 2'h2, timer2HighSel = 2'h3;
   logic timer3CountSel = 1'b0, acceptOn = 1'b0, tcycEn, irqAccept, standbyWake, wakeToRcHalt, wakeToKeepHalt;
   logic haltExit, timer2CountPulse, timer2LowCapture, timer2HighCapture, timer3CountPulse;
   logic [3:0][7:0] count;
   logic [31:0] snap;
   int n_fail = 0, n_checks = 0, cycles = 0;
   always #12.5 clock = ~clock;
   eid_ext_irq_detect i_dut (.*);
   eid_core_model i_core (.clock(clock), .rst(rst), .halted(wakeToRcHalt | wakeToKeepHalt), .acceptOn(acceptOn),
      .pulses({timer3CountPulse, timer2HighCapture, timer2LowCapture, timer2CountPulse}), .tcycEn(tcycEn),
      .irqAccept(irqAccept), .count(count));
   task automatic test_done();
      if (n_fail == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done
   task automatic check(string s, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", s, exp, seen);
      end
   endtask : check
   task automatic step(int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : step
   task automatic wr(logic [15:0] a, logic [7:0] d);
      @(posedge clock);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask : wr
   task automatic rd(logic [15:0] a, logic [7:0] e, string s);
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      #1 check(s, regRdata, e);
   endtask : rd
   task automatic pin(int i, logic v);
      @(posedge clock);
      extIrqPin[i] <= v;
      step(6);
   endtask : pin
   always @(posedge clock) begin
      cycles++;
      if (cycles == 4000) begin
         n_fail++;
         test_done();
      end
   end
   initial begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         rd(AddrCtrl01 + 16'(i), CtrlReset, "reset");
      end
      for (int i = 0; i < 4; i++) begin
         wr(AddrCtrl01 + 16'(i), 8'hcc);
         rd(AddrCtrl01 + 16'(i), 8'hcc, "readback");
      end
      // Polarity and pin move together so the synced level stays idle.
      for (int k = 0; k < 8; k++) begin
         @(posedge clock);
         portInvert[0] <= k[2];
         extIrqPin[0] <= ~k[2];
         step(6);
         wr(AddrCtrl01, {4'h0, k[1:0], 2'b01});
         pin(0, k[2]);
         check("flag", irqRequest[0], k[1:0] != 2'b00);
         wr(AddrCtrl01, {4'h0, k[1:0], 2'b01});
         pin(0, ~k[2]);
         check("sticky", irqRequest[0], k[0]);
         wr(AddrCtrl01, {4'h0, k[1:0], 2'b01});
         step(4);
         check("clear", irqRequest[0], 0);
      end
      wr(AddrCtrl23, 8'h88);
      wr(AddrCtrl45, 8'h88);
      pin(2, 1'b0);
      check("unrouted", count, 0);
      @(posedge clock);
      extIrqPin[5:3] <= 3'b000;
      step(6);
      check("edge", count, 32'h01010101);
      wr(AddrCtrl23, 8'h44);
      wr(AddrCtrl45, 8'h44);
      step(8);
      snap = count;
      step(40);
      check("level", count - snap, 32'h0a0a0a0a);
      pin(7, 1'b0);
      wr(AddrCtrl67, 8'h90);
      @(posedge clock);
      standbyRc <= 1'b1;
      pin(7, 1'b1);
      pin(7, 1'b0);
      check("blocked", {wakeToRcHalt, irqRequest[7]}, 0);
      @(posedge clock);
      standbyRc <= 1'b0;
      pin(7, 1'b1);
      @(posedge clock);
      standbyRc <= 1'b1;
      pin(7, 1'b0);
      check("rc wake", {wakeToRcHalt, irqRequest[7]}, 2'b11);
      @(posedge clock);
      standbyRc <= 1'b0;
      acceptOn <= 1'b1;
      step(4);
      check("run", wakeToRcHalt, 0);
      @(posedge clock);
      acceptOn <= 1'b0;
      standbyKeepOsc <= 1'b1;
      step(3);
      check("keep", {wakeToKeepHalt, wakeToRcHalt}, 2'b10);
      test_done();
   end
endmodule : eid_ext_irq_detect_bench
bind eid_ext_irq_detect eid_ext_irq_checker #(.NumCh(NumCh)) i_chk (.clock(clock), .rst(rst), .regWrite(regWrite),
   .standbyRc(standbyRc), .standbyKeepOsc(standbyKeepOsc), .irqAccept(irqAccept), .irqRequest(irqRequest),
   .standbyWake(standbyWake), .wakeToRcHalt(wakeToRcHalt), .wakeToKeepHalt(wakeToKeepHalt), .haltExit(haltExit),
   .timer2CountPulse(timer2CountPulse));
